// ---- conv_clock_defines.svh ----
`ifndef CONV_CLOCK_DEFINES_SVH
`define CONV_CLOCK_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_CLOCK_ONE 12'h320
`define OFS_CLOCK_TWO 12'h324
`define OFS_GEN_ENABLE 12'h33C
`define OFS_SIGNAL_ROUTE 12'h340
`define OFS_SIGNAL_STATUS 12'h344

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SRC_MSB 30
`define SRC_LSB 29
`define DIV_MSB 27
`define DIV_LSB 0
`define RUN_TWO_BIT 1
`define ROUTE_IO_LSB 0
`define ROUTE_DRIVE_LSB 4
`define ROUTE_SEQ_SEL_BIT 8

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define CLOCK_CFG_RESET 32'h0FFFFFFF
`define SRC_20_MHZ 2'h0
`define SRC_22_MHZ 2'h1
`define SRC_60_MHZ 2'h2
`define SRC_RESERVED 2'h3
`define DIV_RESET 28'hFFFFFFF

`endif

// ---- conv_clock_pkg.sv ----
`default_nettype none
package conv_clock_pkg;

  typedef struct packed {
    logic [1:0] src;
    logic [27:0] div;
  } gen_cfg_s;

  typedef struct packed {
    logic seq_clock_two;
    logic [2:0] drive_out;
    logic [2:0] from_io;
  } route_s;

  typedef struct packed {
    logic level;
    logic tick;
  } conv_sig_s;

  typedef enum logic [1:0] {
    GEN_IDLE = 2'b01,
    GEN_RUN = 2'b10
  } gen_state_e;

endpackage
`default_nettype wire

// ---- clock_divider_gen.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "conv_clock_defines.svh"
module clock_divider_gen
#(
  parameter int DIV_W = 28
)
(
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic run_i,
  input wire logic [2:0] src_tick_i,
  input var conv_clock_pkg::gen_cfg_s cfg_i,
  output var conv_clock_pkg::conv_sig_s sig_o
);
  import conv_clock_pkg::*;

  gen_state_e state_reg;
  gen_state_e state_next;
  logic [DIV_W-1:0] count_reg;
  logic [DIV_W-1:0] count_next;
  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] div_next;
  conv_sig_s sig_reg;
  conv_sig_s sig_next;
  logic src_tick;
  logic [DIV_W:0] half;

  // ----------------------------------------
  // Source tick pick
  // ----------------------------------------
  function automatic logic pick_tick(input logic [1:0] src, input logic [2:0] ticks);
    logic t;
    t = 1'b0;
    unique case (src)
      `SRC_20_MHZ: t = ticks[0];
      `SRC_22_MHZ: t = ticks[1];
      `SRC_60_MHZ: t = ticks[2];
      `SRC_RESERVED: t = 1'b0;
    endcase
    return t;
  endfunction

  always_comb
  begin
    src_tick = pick_tick(cfg_i.src, src_tick_i);
    half = ({1'b0, div_reg} + {{DIV_W{1'b0}}, 1'b1}) >> 1;
    state_next = state_reg;
    count_next = count_reg;
    div_next = div_reg;
    sig_next.tick = 1'b0;
    sig_next.level = 1'b0;
    unique case (state_reg)
      GEN_IDLE:
      begin
        count_next = '0;
        div_next = cfg_i.div;
        if (run_i && (cfg_i.src != `SRC_RESERVED))
        begin
          state_next = GEN_RUN;
        end
      end
      GEN_RUN:
      begin
        sig_next.level = ({1'b0, count_reg} < half);
        if (!run_i || (cfg_i.src == `SRC_RESERVED))
        begin
          state_next = GEN_IDLE;
          sig_next.level = 1'b0;
        end
        else if (src_tick)
        begin
          if (count_reg == div_reg)
          begin
            count_next = '0;
            sig_next.tick = 1'b1;
            div_next = cfg_i.div;
          end
          else
          begin
            count_next = count_reg + {{(DIV_W-1){1'b0}}, 1'b1};
          end
        end
      end
      default:
      begin
        state_next = GEN_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_reg <= GEN_IDLE;
      count_reg <= '0;
      div_reg <= {DIV_W{1'b1}};
      sig_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      count_reg <= count_next;
      div_reg <= div_next;
      sig_reg <= sig_next;
    end
  end

  assign sig_o = sig_reg;
endmodule
`default_nettype wire

// ---- conversion_clock_generators.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "conv_clock_defines.svh"
module conversion_clock_generators
#(
  parameter int ADDR_W = 12,
  parameter int DIV_W = 28
)
(
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic seq_mode_i,
  input wire logic [2:0] src_tick_i,
  input wire logic frame_gen_i,
  input wire logic [2:0] io_conv_i,
  output logic [2:0] io_conv_o,
  output logic [2:0] io_conv_oe_o,
  output logic conv_clock_one_o,
  output logic conv_clock_two_o,
  output logic seq_conv_tick_o,
  output logic frame_start_o
);
  import conv_clock_pkg::*;

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  gen_cfg_s cfg_one_reg;
  gen_cfg_s cfg_one_next;
  gen_cfg_s cfg_two_reg;
  gen_cfg_s cfg_two_next;
  logic run_two_reg;
  logic run_two_next;
  route_s route_reg;
  route_s route_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // ----------------------------------------
  // Signal path state
  // ----------------------------------------
  logic [2:0] io_prev_reg;
  logic [2:0] io_prev_next;
  logic [2:0] level_reg;
  logic [2:0] level_next;
  logic [2:0] io_out_reg;
  logic [2:0] io_out_next;
  logic [2:0] io_oe_reg;
  logic [2:0] io_oe_next;
  logic seq_tick_reg;
  logic seq_tick_next;
  logic frame_prev_reg;
  logic frame_prev_next;
  logic frame_pending_reg;
  logic frame_pending_next;
  logic frame_start_reg;
  logic frame_start_next;

  conv_sig_s sig_one;
  conv_sig_s sig_two;
  logic [2:0] gen_level;
  logic [2:0] gen_tick;
  logic [2:0] sel_level;
  logic [2:0] sel_tick;
  logic seq_tick;
  logic frame_rise;
  logic [2:0] io_rise;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [11:0] ofs);
    return addr == ADDR_W'(ofs);
  endfunction

  function automatic logic [31:0] pack_cfg(input gen_cfg_s cfg);
    return {1'b0, cfg.src, 1'b0, cfg.div};
  endfunction

  function automatic gen_cfg_s unpack_cfg(input logic [31:0] data);
    gen_cfg_s cfg;
    cfg.src = data[`SRC_MSB:`SRC_LSB];
    cfg.div = data[`DIV_MSB:`DIV_LSB];
    return cfg;
  endfunction

  function automatic route_s unpack_route(input logic [31:0] data);
    route_s route;
    route.from_io = data[`ROUTE_IO_LSB+2:`ROUTE_IO_LSB];
    route.drive_out = data[`ROUTE_DRIVE_LSB+2:`ROUTE_DRIVE_LSB];
    route.seq_clock_two = data[`ROUTE_SEQ_SEL_BIT];
    return route;
  endfunction

  function automatic logic [31:0] pack_route(input route_s route);
    logic [31:0] data;
    data = 32'h00000000;
    data[`ROUTE_IO_LSB+2:`ROUTE_IO_LSB] = route.from_io;
    data[`ROUTE_DRIVE_LSB+2:`ROUTE_DRIVE_LSB] = route.drive_out;
    data[`ROUTE_SEQ_SEL_BIT] = route.seq_clock_two;
    return data;
  endfunction

  function automatic logic [31:0] pack_status(input logic [2:0] levels, input logic pending);
    logic [31:0] data;
    data = 32'h00000000;
    data[2:0] = levels;
    data[4] = pending;
    return data;
  endfunction

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always_comb
  begin
    cfg_one_next = cfg_one_reg;
    cfg_two_next = cfg_two_reg;
    run_two_next = run_two_reg;
    route_next = route_reg;
    rdata_next = 32'h00000000;
    if (wr_i)
    begin
      if (hit(addr_i, `OFS_CLOCK_ONE))
      begin
        cfg_one_next = unpack_cfg(wdata_i);
      end
      if (hit(addr_i, `OFS_CLOCK_TWO))
      begin
        cfg_two_next = unpack_cfg(wdata_i);
      end
      if (hit(addr_i, `OFS_GEN_ENABLE))
      begin
        run_two_next = wdata_i[`RUN_TWO_BIT];
      end
      if (hit(addr_i, `OFS_SIGNAL_ROUTE))
      begin
        route_next = unpack_route(wdata_i);
      end
    end
    if (rd_i)
    begin
      if (hit(addr_i, `OFS_CLOCK_ONE))
      begin
        rdata_next = pack_cfg(cfg_one_reg);
      end
      else if (hit(addr_i, `OFS_CLOCK_TWO))
      begin
        rdata_next = pack_cfg(cfg_two_reg);
      end
      else if (hit(addr_i, `OFS_GEN_ENABLE))
      begin
        rdata_next[`RUN_TWO_BIT] = run_two_reg;
      end
      else if (hit(addr_i, `OFS_SIGNAL_ROUTE))
      begin
        rdata_next = pack_route(route_reg);
      end
      else if (hit(addr_i, `OFS_SIGNAL_STATUS))
      begin
        rdata_next = pack_status(level_reg, frame_pending_reg);
      end
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cfg_one_reg <= {`SRC_20_MHZ, `DIV_RESET};
      cfg_two_reg <= {`SRC_20_MHZ, `DIV_RESET};
      run_two_reg <= 1'b0;
      route_reg <= '0;
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      cfg_one_reg <= cfg_one_next;
      cfg_two_reg <= cfg_two_next;
      run_two_reg <= run_two_next;
      route_reg <= route_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------
  // On-board generators
  // ----------------------------------------
  clock_divider_gen #(
    .DIV_W(DIV_W)
  ) u_gen_one (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .run_i(seq_mode_i),
    .src_tick_i(src_tick_i),
    .cfg_i(cfg_one_reg),
    .sig_o(sig_one)
  );

  clock_divider_gen #(
    .DIV_W(DIV_W)
  ) u_gen_two (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .run_i(seq_mode_i && run_two_reg),
    .src_tick_i(src_tick_i),
    .cfg_i(cfg_two_reg),
    .sig_o(sig_two)
  );

  assign gen_level = {frame_gen_i, sig_two.level, sig_one.level};
  assign gen_tick = {frame_gen_i && !frame_prev_reg, sig_two.tick, sig_one.tick};

  // ----------------------------------------
  // Per-signal source pick
  // ----------------------------------------
  assign io_rise = io_conv_i & ~io_prev_reg;

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++)
    begin : g_chan
      // Generator or I/O line; I/O tick marks a rising edge, generator tick comes from gen_tick
      assign sel_level[ch] = route_reg.from_io[ch] ? io_conv_i[ch] : gen_level[ch];
      assign sel_tick[ch] = route_reg.from_io[ch] ? io_rise[ch] : gen_tick[ch];
    end
  endgenerate

  assign seq_tick = route_reg.seq_clock_two ? sel_tick[1] : sel_tick[0];
  assign frame_rise = sel_tick[2];

  // ----------------------------------------
  // Signal path
  // ----------------------------------------
  always_comb
  begin
    io_prev_next = io_conv_i;
    frame_prev_next = frame_gen_i;
    level_next = '0;
    io_out_next = '0;
    io_oe_next = '0;
    seq_tick_next = 1'b0;
    frame_start_next = 1'b0;
    frame_pending_next = 1'b0;
    if (seq_mode_i)
    begin
      level_next = sel_level;
      io_oe_next = route_reg.drive_out & ~route_reg.from_io;
      io_out_next = gen_level & io_oe_next;
      seq_tick_next = seq_tick;
      frame_pending_next = frame_pending_reg;
      if (seq_tick && (frame_pending_reg || frame_rise))
      begin
        frame_start_next = 1'b1;
        frame_pending_next = 1'b0;
      end
      if (frame_rise && !seq_tick)
      begin
        frame_pending_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      io_prev_reg <= '0;
      frame_prev_reg <= 1'b0;
      level_reg <= '0;
      io_out_reg <= '0;
      io_oe_reg <= '0;
      seq_tick_reg <= 1'b0;
      frame_start_reg <= 1'b0;
      frame_pending_reg <= 1'b0;
    end
    else
    begin
      io_prev_reg <= io_prev_next;
      frame_prev_reg <= frame_prev_next;
      level_reg <= level_next;
      io_out_reg <= io_out_next;
      io_oe_reg <= io_oe_next;
      seq_tick_reg <= seq_tick_next;
      frame_start_reg <= frame_start_next;
      frame_pending_reg <= frame_pending_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata_o = rdata_reg;
  assign io_conv_o = io_out_reg;
  assign io_conv_oe_o = io_oe_reg;
  assign conv_clock_one_o = level_reg[0];
  assign conv_clock_two_o = level_reg[1];
  assign seq_conv_tick_o = seq_tick_reg;
  assign frame_start_o = frame_start_reg;
endmodule
`default_nettype wire

// ---- conv_clock_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module conv_clock_chk
#(
  parameter int ADDR_W = 12
)
(
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic seq_mode_i,
  input wire logic conv_clock_one_o,
  input wire logic conv_clock_two_o,
  input wire logic seq_conv_tick_o,
  input wire logic frame_start_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!arst_n_i);
  // ----------
  // Sequences
  // ----------
  sequence read_of(logic [11:0] a);
    rd_i && addr_i == a ##1 1'b1;
  endsequence
  sequence mode_off;
    !seq_mode_i [*3];
  endsequence
  // ----------
  // Checks
  // ----------
  chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data not zero");
  chk_mode_off: assert property (mode_off |-> !conv_clock_one_o && !conv_clock_two_o
    && !seq_conv_tick_o && !frame_start_o) else $error("output while mode off");
  chk_mode_tick: assert property (seq_conv_tick_o |-> $past(seq_mode_i))
    else $error("tick without mode");
  chk_frame_tick: assert property (frame_start_o |-> seq_conv_tick_o)
    else $error("frame start without tick");
  chk_one_read: assert property (read_of(12'h320) |-> !rdata_o[31] && !rdata_o[28])
    else $error("clock one reserved bits set");
  chk_two_read: assert property (read_of(12'h324) |-> !rdata_o[31] && !rdata_o[28])
    else $error("clock two reserved bits set");
  chk_unmapped_read: assert property (read_of(12'h000) |-> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  chk_run_read: assert property (read_of(12'h33C) |-> rdata_o[31:2] == 30'h0 && !rdata_o[0])
    else $error("run register reserved bits set");
  chk_route_read: assert property (read_of(12'h340) |-> rdata_o[31:9] == 23'h0)
    else $error("route reserved bits set");
endmodule
bind conversion_clock_generators conv_clock_chk #(.ADDR_W(ADDR_W)) i_chk (
  .clock_i(clock_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .seq_mode_i(seq_mode_i), .conv_clock_one_o(conv_clock_one_o),
  .conv_clock_two_o(conv_clock_two_o), .seq_conv_tick_o(seq_conv_tick_o),
  .frame_start_o(frame_start_o));
`default_nettype wire

// ---- src_io_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module src_io_model
#(
  parameter int PER0 = 5,
  parameter int PER1 = 4,
  parameter int PER2 = 2
)
(
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic io_en_i,
  output logic [2:0] src_tick_o,
  output logic [2:0] io_o
);
  logic [31:0] cnt_reg;
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt_reg <= 32'h0;
      src_tick_o <= 3'h0;
      io_o <= 3'h0;
    end
    else
    begin
      cnt_reg <= cnt_reg + 32'h1;
      // Source enables at fixed rates
      src_tick_o[0] <= (cnt_reg % PER0) == 0;
      src_tick_o[1] <= (cnt_reg % PER1) == 0;
      src_tick_o[2] <= (cnt_reg % PER2) == 0;
      // With io_en_i set all lines follow counter bits 4:2, else all lines toggle every cycle
      io_o <= io_en_i ? {cnt_reg[4], cnt_reg[3], cnt_reg[2]} : ~io_o;
    end
  end
endmodule
`default_nettype wire

// ---- conversion_clock_generators_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module conversion_clock_generators_tb;
  localparam int P0 = 5;
  localparam int P1 = 4;
  localparam int P2 = 2;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [11:0] addr_i = 12'h000;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic seq_mode_i = 1'b0;
  logic frame_gen_i = 1'b0;
  logic io_en = 1'b0;
  logic [31:0] seed = 32'd74571;
  logic [31:0] rdata;
  logic [2:0] src_tick;
  logic [2:0] io_in;
  logic [2:0] io_out;
  logic [2:0] io_oe;
  logic conv_one;
  logic conv_two;
  logic seq_tick;
  logic frame_start;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  always #5 clock_i = ~clock_i;
  conversion_clock_generators i_dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .seq_mode_i(seq_mode_i),
    .src_tick_i(src_tick), .frame_gen_i(frame_gen_i), .io_conv_i(io_in), .io_conv_o(io_out),
    .io_conv_oe_o(io_oe), .conv_clock_one_o(conv_one), .conv_clock_two_o(conv_two),
    .seq_conv_tick_o(seq_tick), .frame_start_o(frame_start));
  src_io_model #(.PER0(P0), .PER1(P1), .PER2(P2)) i_model (.clock_i(clock_i),
    .arst_n_i(arst_n_i), .io_en_i(io_en), .src_tick_o(src_tick), .io_o(io_in));
  // ----------
  // Helpers
  // ----------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic int per(input int s);
    return (s == 0) ? P0 : (s == 1) ? P1 : P2;
  endfunction
  task automatic final_report();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    check(rdata, exp);
    @(posedge clock_i);
  endtask
  task automatic gap(input int exp);
    int n;
    n = 0;
    repeat (3)
    begin
      n = 0;
      do @(negedge clock_i); while (++n < 3000 && seq_tick !== 1'b1);
    end
    check(n, exp);
    @(posedge clock_i);
  endtask
  task automatic quiet();
    int n;
    n = 0;
    repeat (20) @(posedge clock_i);
    repeat (60)
    begin
      @(negedge clock_i);
      if (seq_tick !== 1'b0)
        n++;
    end
    check(n, 0);
    @(posedge clock_i);
  endtask
  task automatic highs(input logic two, input int len, input int exp, input int exp_io);
    int h;
    int g;
    h = 0;
    g = 0;
    repeat (len)
    begin
      @(negedge clock_i);
      if ((two ? conv_two : conv_one) === 1'b1)
        h++;
      if (io_out === 3'b001)
        g++;
    end
    check(h, exp);
    check(g, exp_io);
    @(posedge clock_i);
  endtask
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      final_report();
    end
  end
  // ----------
  // Sequence
  // ----------
  initial
  begin
    int s;
    int d;
    int k;
    repeat (5) @(posedge clock_i);
    arst_n_i <= 1'b1;
    @(posedge clock_i);
    rd(12'h320, 32'h0FFFFFFF);
    rd(12'h324, 32'h0FFFFFFF);
    rd(12'h33C, 32'h0);
    rd(12'h340, 32'h0);
    wr(12'h000, 32'hFFFFFFFF);
    rd(12'h000, 32'h0);
    repeat (4)
    begin
      d = int'(rnd());
      wr(12'h324, d);
      rd(12'h324, d & 32'h6FFFFFFF);
    end
    wr(12'h320, 32'hFFFFFFFF);
    rd(12'h320, 32'h6FFFFFFF);
    for (s = 0; s < 3; s++)
    begin
      d = int'(rnd() % 32'd4);
      wr(12'h320, {1'b0, s[1:0], 1'b0, d[27:0]});
      seq_mode_i <= 1'b1;
      gap(per(s) * (d + 1));
    end
    d = int'(rnd() % 32'd4);
    wr(12'h324, {1'b0, 2'b10, 1'b0, d[27:0]});
    wr(12'h340, 32'h100);
    wr(12'h33C, 32'h2);
    gap(P2 * (d + 1));
    highs(1'b1, 8 * (d + 1), 8 * ((d + 1) / 2), 0);
    wr(12'h33C, 32'h0);
    quiet();
    wr(12'h33C, 32'h2);
    wr(12'h324, 32'h60000003);
    quiet();
    wr(12'h320, 32'h40000003);
    wr(12'h340, 32'h10);
    repeat (12) @(negedge clock_i);
    check(io_oe, 3'b001);
    @(posedge clock_i);
    highs(1'b0, 32, 16, 16);
    wr(12'h340, 32'h11);
    io_en <= 1'b1;
    repeat (3) @(negedge clock_i);
    check(io_oe, 3'b000);
    @(posedge clock_i);
    gap(8);
    wr(12'h340, 32'h0);
    io_en <= 1'b0;
    frame_gen_i <= 1'b1;
    @(posedge clock_i);
    frame_gen_i <= 1'b0;
    k = 0;
    do @(negedge clock_i); while (++k < 200 && frame_start !== 1'b1);
    check(k < 200, 1'b1);
    @(posedge clock_i);
    seq_mode_i <= 1'b0;
    quiet();
    rd(12'h344, 32'h0);
    final_report();
  end
endmodule
`default_nettype wire
